// [rtl/vpiu_pkg.sv]
// Constants for the vectored priority interrupt unit
package vpiu_pkg;

    // Widths
    localparam int NSRC   = 14;
    localparam int NPIN   = 8;
    localparam int ADDR_W = 12;
    localparam int NSTAT  = 3;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_EDGE  = 8'h3A;
    localparam logic [7:0] IDX_REQ1  = 8'h3C;
    localparam logic [7:0] IDX_REQ2  = 8'h3D;
    localparam logic [7:0] IDX_EN1   = 8'h3E;
    localparam logic [7:0] IDX_EN2   = 8'h3F;
    localparam logic [7:0] IDX_PSTAT = 8'h40;
    localparam logic [7:0] IDX_ISTAT = 8'h41;
    localparam logic [7:0] IDX_IMASK = 8'h42;

    // Reset values
    localparam logic [7:0]  EDGE_RST  = 8'h00;
    localparam logic [13:0] REQ_RST   = 14'h0000;
    localparam logic [13:0] EN_RST    = 14'h0000;
    localparam logic [2:0]  STAT_RST  = 3'h0;

    // Processor status field
    localparam int PS_IDIS_BIT = 2;

    // Interrupt status bits
    localparam int ST_ACCEPT = 0;
    localparam int ST_BRK    = 1;
    localparam int ST_LOST   = 2;

    // Peripheral request input positions
    localparam int PER_SRX = 0;
    localparam int PER_STX = 1;
    localparam int PER_T1  = 4;

    // Vector addresses
    localparam logic [15:0] VEC_RESET_HI = 16'hFFFD;
    localparam logic [15:0] VEC_RESET_LO = 16'hFFFC;
    localparam logic [15:0] VEC_FIRST_HI = 16'hFFFB;
    localparam logic [15:0] VEC_BRK_HI   = 16'hFFDD;
    localparam logic [15:0] VEC_BRK_LO   = 16'hFFDC;
    localparam logic [15:0] VEC_LO_OFS   = 16'h0001;

endpackage

// [rtl/vpiu_top.sv]
// Vectored fixed-priority interrupt unit with APB register access
// Operation
// - Fifteen hardware sources, each with its own vector, fixed priority order.
// - Simultaneous pending requests: highest priority granted first, others stay pending.
// - Maskable sources gated by own enable bit and global disable flag.
// - Reset highest priority vector FFFD/FFFC; break lowest, vector FFDD/FFDC.
// - Serial receive priority 4, vector FFF7/FFF6, only when serial selected.
// - Serial transmit priority 5, vector FFF5/FFF4, only when serial selected.
// - Timer 1 priority 8, vector FFEF/FFEE; underflow ends stop wait.
// - Remaining order fixed; vectors descend two bytes per step to FFE1/FFE0.
// - Maskable and break service starts only at an instruction boundary; reset service starts at once.
// - Request register writes take effect late; software waits one instruction.
// - After reset the global disable flag is one.
// - Edge selection register picks external pin edges, resets to zero.
`timescale 1ns/1ps
`default_nettype none

module vpiu_top
    import vpiu_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    // APB slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // Asynchronous request pins
    input  wire logic [5:0]        i_ext_irq_pin,
    input  wire logic [1:0]        i_counter_pin,
    // On-chip peripheral requests
    input  wire logic [5:0]        i_periph_req,
    input  wire logic              i_serial_sel,
    input  wire logic              i_stop_wait,
    // CPU core
    input  wire logic              i_instr_done,
    input  wire logic              i_break_instruction,
    input  wire logic              i_set_idis,
    input  wire logic              i_clr_idis,
    output logic                   o_int_pending,
    output logic                   o_take,
    output logic [15:0]            o_vec_hi_addr,
    output logic [15:0]            o_vec_lo_addr,
    output logic                   o_idis,
    output logic                   o_stop_release,
    // Interrupt to system
    output logic                   o_irq
);

    // Lowest set index wins
    function automatic logic [3:0] prio_pick(input logic [NSRC-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int k = NSRC - 1; k >= 0; k--) begin
            if (v[k]) begin
                idx = 4'(k);
            end
        end
        return idx;
    endfunction

    // Vector high byte address for a source index
    function automatic logic [15:0] vec_hi(input logic [3:0] idx);
        return VEC_FIRST_HI - {11'h000, idx, 1'b0};
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return (a == {2'h0, idx, 2'h0});
    endfunction

    // Upper bank of a request-layout word, zero extended
    function automatic logic [7:0] hi_byte(input logic [NSRC-1:0] v);
        return {2'h0, v[13:8]};
    endfunction

    // Replace one byte bank of a request-layout word
    function automatic logic [NSRC-1:0] lane_put(input logic [NSRC-1:0] base,
                                                 input logic            hi,
                                                 input logic [7:0]      b);
        return hi ? {b[5:0], base[7:0]} : {base[13:8], b};
    endfunction

    // State
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] sync2_q;
    logic [NPIN-1:0] prev_q;
    logic [7:0]      edge_q;
    logic [NSRC-1:0] req_q;
    logic [NSRC-1:0] req_d;
    logic [NSRC-1:0] en_q;
    logic [NSRC-1:0] en_d;
    logic            idis_q;
    logic            idis_d;
    logic            reset_pend_q;
    logic            brk_pend_q;
    logic            brk_pend_d;
    logic            stage_q;
    logic            stage_sel_q;
    logic [7:0]      stage_data_q;
    logic [NSTAT-1:0] stat_q;
    logic [NSTAT-1:0] stat_d;
    logic [NSTAT-1:0] mask_q;
    logic [31:0]     prdata_q;
    logic            pready_q;
    logic            pslverr_q;
    logic            take_q;
    logic [15:0]     vec_hi_q;
    logic [15:0]     vec_lo_q;
    logic            pend_q;
    logic            stop_rel_q;
    logic            irq_q;

    // Pin synchronisers and edge detection
    wire [NPIN-1:0] pin_raw = {i_counter_pin, i_ext_irq_pin};
    wire [NPIN-1:0] pin_ev;

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            assign pin_ev[g] = edge_q[g] ? (sync2_q[g] & ~prev_q[g])
                                         : (~sync2_q[g] & prev_q[g]);
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Source events in priority order
    wire       ser_ok = i_serial_sel;
    wire [1:0] ser_ev = {i_periph_req[PER_STX] & ser_ok,
                         i_periph_req[PER_SRX] & ser_ok};
    wire [NSRC-1:0] src_ev = {pin_ev[5:2], pin_ev[7:6], i_periph_req[5:2],
                              ser_ev, pin_ev[1:0]};

    // Arbitration
    wire [NSRC-1:0] eligible = req_q & en_q & {NSRC{~idis_q}};
    wire            any_mask = |eligible;
    wire [3:0]      pick     = prio_pick(eligible);
    wire            boundary = i_instr_done & ~reset_pend_q;
    wire            take_mask = boundary & any_mask;
    wire            take_brk  = boundary & ~any_mask & brk_pend_q;
    wire            take_any  = reset_pend_q | take_mask | take_brk;
    wire [NSRC-1:0] clr_vec  = take_mask ? (NSRC'(1) << pick) : '0;
    wire [15:0]     sel_hi   = reset_pend_q ? VEC_RESET_HI :
                               take_mask    ? vec_hi(pick) : VEC_BRK_HI;
    wire [15:0]     sel_lo   = reset_pend_q ? VEC_RESET_LO :
                               take_mask    ? (vec_hi(pick) - VEC_LO_OFS) : VEC_BRK_LO;

    // APB decode
    wire acc      = i_psel & i_penable;
    wire fire     = acc & pready_q;
    wire wr_fire  = fire & i_pwrite;
    wire hit_edge = reg_hit(i_paddr, IDX_EDGE);
    wire hit_req1 = reg_hit(i_paddr, IDX_REQ1);
    wire hit_req2 = reg_hit(i_paddr, IDX_REQ2);
    wire hit_en1  = reg_hit(i_paddr, IDX_EN1);
    wire hit_en2  = reg_hit(i_paddr, IDX_EN2);
    wire hit_ps   = reg_hit(i_paddr, IDX_PSTAT);
    wire hit_st   = reg_hit(i_paddr, IDX_ISTAT);
    wire hit_mk   = reg_hit(i_paddr, IDX_IMASK);
    wire hit_any  = hit_edge | hit_req1 | hit_req2 | hit_en1 | hit_en2 |
                    hit_ps | hit_st | hit_mk;
    wire [7:0] wbyte = i_pwdata[7:0];

    wire [7:0] ps_view = 8'(idis_q) << PS_IDIS_BIT;
    wire [7:0] rd_byte = hit_edge ? edge_q :
                         hit_req1 ? req_q[7:0] :
                         hit_req2 ? hi_byte(req_q) :
                         hit_en1  ? en_q[7:0] :
                         hit_en2  ? hi_byte(en_q) :
                         hit_ps   ? ps_view :
                         hit_st   ? {5'h00, stat_q} :
                         hit_mk   ? {5'h00, mask_q} : 8'h00;

    // Request update: staged write applies one cycle late, set wins over clear
    wire [NSRC-1:0] keep = !stage_q ? {NSRC{1'b1}} :
                           lane_put({NSRC{1'b1}}, stage_sel_q, stage_data_q);
    assign req_d = (req_q & keep & ~clr_vec) | src_ev;

    wire en_wr = wr_fire & (hit_en1 | hit_en2);
    assign en_d = en_wr ? lane_put(en_q, hit_en2, wbyte) : en_q;

    // Disable flag: accept sets, then software or CPU may change it
    assign idis_d = take_any                 ? 1'b1 :
                    (wr_fire & hit_ps)       ? wbyte[PS_IDIS_BIT] :
                    i_set_idis               ? 1'b1 :
                    i_clr_idis               ? 1'b0 : idis_q;

    assign brk_pend_d = i_break_instruction | (brk_pend_q & ~take_brk);

    // Sticky status, write one to clear, set wins
    wire [NSTAT-1:0] st_ev  = {|(src_ev & req_q), take_brk, take_mask};
    wire [NSTAT-1:0] st_clr = (wr_fire & hit_st) ? wbyte[NSTAT-1:0] : '0;
    assign stat_d = (stat_q & ~st_clr) | st_ev;

    // Edge selection register
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            edge_q <= EDGE_RST;
        end else if (wr_fire & hit_edge) begin
            edge_q <= wbyte;
        end
    end

    // Interrupt status mask
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            mask_q <= STAT_RST;
        end else if (wr_fire & hit_mk) begin
            mask_q <= wbyte[NSTAT-1:0];
        end
    end

    // Request and enable bits
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            req_q <= REQ_RST;
            en_q  <= EN_RST;
        end else begin
            req_q <= req_d;
            en_q  <= en_d;
        end
    end

    // Disable flag; reset service owed once after reset
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            idis_q       <= 1'b1;
            reset_pend_q <= 1'b1;
        end else begin
            idis_q       <= idis_d;
            reset_pend_q <= 1'b0;
        end
    end

    // Break latch and sticky status
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            brk_pend_q <= 1'b0;
            stat_q     <= STAT_RST;
        end else begin
            brk_pend_q <= brk_pend_d;
            stat_q     <= stat_d;
        end
    end

    // Request register write staging
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            stage_q      <= 1'b0;
            stage_sel_q  <= 1'b0;
            stage_data_q <= 8'h00;
        end else begin
            stage_q      <= wr_fire & (hit_req1 | hit_req2);
            stage_sel_q  <= hit_req2;
            stage_data_q <= wbyte;
        end
    end

    // APB answer: one wait state
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~hit_any;
        end
    end

    // Read data stands only with pready, zero otherwise
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= (acc & ~pready_q & ~i_pwrite) ? {24'h000000, rd_byte}
                                                      : 32'h0000_0000;
        end
    end

    // CPU side outputs
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            take_q <= 1'b0;
        end else begin
            take_q <= take_any;
        end
    end

    // Vectors held until the next accept
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            vec_hi_q <= VEC_RESET_HI;
            vec_lo_q <= VEC_RESET_LO;
        end else if (take_any) begin
            vec_hi_q <= sel_hi;
            vec_lo_q <= sel_lo;
        end
    end

    // Pending and interrupt levels
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pend_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            pend_q <= any_mask | brk_pend_q;
            irq_q  <= |(stat_d & mask_q);
        end
    end

    // Stop wait ends on the timer 1 event
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            stop_rel_q <= 1'b0;
        end else begin
            stop_rel_q <= i_stop_wait & i_periph_req[PER_T1];
        end
    end

    assign o_prdata       = prdata_q;
    assign o_pready       = pready_q;
    assign o_pslverr      = pslverr_q;
    assign o_take         = take_q;
    assign o_vec_hi_addr  = vec_hi_q;
    assign o_vec_lo_addr  = vec_lo_q;
    assign o_idis         = idis_q;
    assign o_int_pending  = pend_q;
    assign o_stop_release = stop_rel_q;
    assign o_irq          = irq_q;

endmodule

`default_nettype wire

// [sim/vpiu_checker.sv]
// Port assertions for the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module vpiu_checker
    import vpiu_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        o_pready,
    input  wire logic        o_pslverr,
    input  wire logic [5:0]  i_periph_req,
    input  wire logic        i_stop_wait,
    input  wire logic        i_instr_done,
    input  wire logic        o_take,
    input  wire logic [15:0] o_vec_hi_addr,
    input  wire logic [15:0] o_vec_lo_addr,
    input  wire logic        o_idis,
    input  wire logic        o_stop_release
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire logic mskb = o_vec_hi_addr != VEC_RESET_HI && o_vec_hi_addr != VEC_BRK_HI;
    AST_RESET_TAKE: assert property ($rose(i_rst_n) |-> ##[0:1] (o_take && o_idis
        && o_vec_hi_addr == VEC_RESET_HI && o_vec_lo_addr == VEC_RESET_LO)) else $error("reset take");
    AST_BOUNDARY: assert property (o_take && o_vec_hi_addr != VEC_RESET_HI
        |-> $past(i_instr_done)) else $error("take off boundary");
    AST_TAKE_IDIS: assert property (o_take |-> o_idis) else $error("take no disable");
    AST_VEC_PAIR: assert property (o_take
        |-> o_vec_lo_addr == o_vec_hi_addr - 16'h0001) else $error("vector pair");
    AST_VEC_RANGE: assert property (o_take && mskb |-> o_vec_hi_addr <= VEC_FIRST_HI
        && o_vec_hi_addr >= 16'hFFE1 && o_vec_hi_addr[0]) else $error("vector range");
    AST_MASK_IDIS: assert property (o_take && mskb
        |-> !$past(o_idis)) else $error("take while disabled");
    AST_VEC_HOLD: assert property (!o_take |-> $stable(o_vec_hi_addr))
        else $error("vector moved");
    AST_STOP_REL: assert property (i_periph_req[PER_T1] && i_stop_wait
        |=> o_stop_release) else $error("no stop release");
    AST_STOP_CAUSE: assert property (o_stop_release
        |-> $past(i_periph_req[PER_T1] && i_stop_wait)) else $error("stray stop release");
    AST_APB_WAIT: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("pready late");
    AST_SLVERR: assert property (o_pslverr |-> o_pready) else $error("lone slverr");
    COV_BRK: cover property (o_take && o_vec_hi_addr == VEC_BRK_HI);
    COV_MASK: cover property (o_take && mskb);
    COV_ERR: cover property (o_pslverr);
endmodule
bind vpiu_top vpiu_checker u_chk (.i_clock, .i_rst_n, .i_psel, .i_penable, .o_pready,
    .o_pslverr, .i_periph_req, .i_stop_wait, .i_instr_done, .o_take, .o_vec_hi_addr,
    .o_vec_lo_addr, .o_idis, .o_stop_release);
`default_nettype wire

// [sim/vpiu_cpu_model.sv]
// Behavioural CPU core: boundaries, break and flag pulses
`timescale 1ns/1ps
`default_nettype none
module vpiu_cpu_model (
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // Bench commands
    input  wire logic       i_step,
    input  wire logic [3:0] i_dly,
    input  wire logic       i_brk,
    input  wire logic [1:0] i_op,
    // Towards the unit
    output logic            o_instr_done,
    output logic            o_break_instruction,
    output logic            o_set_idis,
    output logic            o_clr_idis
);
    logic [4:0] cnt_q;
    // Boundary two or more cycles after a step, slow when delay is large
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            cnt_q <= 5'h00;
        end else if (i_step) begin
            cnt_q <= {1'h0, i_dly} + 5'h02;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end
    end
    always_ff @(posedge i_clock) begin
        o_instr_done        <= i_rst_n && cnt_q == 5'h01;
        o_break_instruction <= i_rst_n && i_step && i_brk;
        o_set_idis          <= i_rst_n && i_op == 2'h2;
        o_clr_idis          <= i_rst_n && i_op == 2'h1;
    end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Random and directed testbench of the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import vpiu_pkg::*;
    logic        i_clock = 1'h0, i_rst_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0;
    logic        i_pwrite = 1'h0, i_serial_sel = 1'h0, i_stop_wait = 1'h0, step = 1'h0;
    logic        break_instruction = 1'h0, err, o_pready, o_pslverr, o_int_pending, o_take, o_idis;
    logic        o_stop_release, o_irq, i_instr_done, i_break_instruction, i_set_idis, i_clr_idis;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, lf = 32'h2DFE, r;
    logic [5:0]  i_ext_irq_pin = 6'h3F, i_periph_req = 6'h00;
    logic [1:0]  i_counter_pin = 2'h3, op = 2'h0;
    logic [3:0]  dly = 4'h0;
    logic [13:0] pend, en, pm;
    logic [15:0] o_vec_hi_addr, o_vec_lo_addr;
    int          n_mismatch = 0, n_checks = 0, cyc = 0;
    always #25 i_clock = ~i_clock;
    vpiu_top u_dut (.i_clock, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_ext_irq_pin, .i_counter_pin, .i_periph_req,
        .i_serial_sel, .i_stop_wait, .i_instr_done, .i_break_instruction, .i_set_idis,
        .i_clr_idis, .o_int_pending, .o_take, .o_vec_hi_addr, .o_vec_lo_addr, .o_idis,
        .o_stop_release, .o_irq);
    vpiu_cpu_model u_cpu (.i_clock, .i_rst_n, .i_step(step), .i_dly(dly), .i_brk(break_instruction),
        .i_op(op), .o_instr_done(i_instr_done), .o_break_instruction(i_break_instruction),
        .o_set_idis(i_set_idis), .o_clr_idis(i_clr_idis));
    function automatic logic [31:0] nx();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction
    // Vector of the lowest set index
    function automatic logic [15:0] vec(input logic [13:0] m);
        vec = 16'h0000;
        for (int i = 13; i >= 0; i--) if (m[i]) vec = VEC_FIRST_HI - 16'(2 * i);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge i_clock) i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= {24'h000000, d};
        @(posedge i_clock) i_penable <= 1'h1;
        do @(posedge i_clock); while (o_pready !== 1'h1);
        q = o_prdata;
        err = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1'h1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        logic [31:0] q;
        apb(1'h0, a, 8'h00, q);
        chk(16'(q & {24'h000000, m}), 16'(e));
    endtask
    task automatic rq(input logic [13:0] p);
        rd(ad(IDX_REQ1), p[7:0], 8'hFF);
        rd(ad(IDX_REQ2), {2'h0, p[13:8]}, 8'hFF);
    endtask
    // One instruction from the core, then wait for a service
    task automatic run(input logic [1:0] c, input logic ex, input logic [15:0] ev);
        int k;
        op <= c;
        step <= 1'h1;
        void'(nx());
        dly <= lf[3:0];
        @(posedge i_clock) step <= 1'h0;
        op <= 2'h0;
        break_instruction <= 1'h0;
        for (k = 0; k < 40 && o_take !== 1'h1; k++) @(posedge i_clock);
        chk(16'(o_take), 16'(ex));
        if (ex) chk(o_vec_hi_addr, ev);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (16) @(posedge i_clock);
        i_rst_n <= 1'h1;
        run(2'h0, 1'h1, VEC_RESET_HI);
        chk(o_vec_lo_addr, VEC_RESET_LO);
        rd(ad(IDX_EDGE), 8'h00, 8'hFF);
        rq(14'h0000);
        rd(ad(IDX_EN2), 8'h00, 8'hFF);
        rd(ad(IDX_PSTAT), 8'h04, 8'h04);
        rd(12'h004, 8'h00, 8'h00);
        chk(16'(err), 16'h0001);
        i_stop_wait <= 1'h1;
        i_periph_req <= 6'h10;
        @(posedge i_clock) i_periph_req <= 6'h00;
        @(posedge i_clock) chk(16'(o_stop_release), 16'h0001);
        i_stop_wait <= 1'h0;
        wr(ad(IDX_REQ1), 8'h00);
        rq(14'h0000);
        repeat (6) begin
            r = nx();
            i_serial_sel <= r[20];
            wr(ad(IDX_EDGE), r[31:24]);
            i_ext_irq_pin <= ~r[5:0];
            i_counter_pin <= ~r[7:6];
            i_periph_req <= r[13:8];
            @(posedge i_clock) i_periph_req <= 6'h00;
            repeat (6) @(posedge i_clock);
            pm = {r[5:2], r[7:6], r[13:8] & {4'hF, {2{r[20]}}}, r[1:0]};
            rq(pm & ~{r[29:26], r[31:30], 6'h00, r[25:24]});
            i_ext_irq_pin <= 6'h3F;
            i_counter_pin <= 2'h3;
            repeat (6) @(posedge i_clock);
            pend = pm;
            rq(pend);
            r = nx();
            en = r[13:0];
            wr(ad(IDX_EN1), en[7:0]);
            wr(ad(IDX_EN2), {2'h0, en[13:8]});
            wr(ad(IDX_PSTAT), 8'h00);
            repeat (2) @(posedge i_clock);
            chk(16'(o_int_pending), 16'((pend & en) != 14'h0000));
            run(2'h2, 1'h0, 16'h0000);
            while ((pend & en) != 14'h0000) begin
                pm = pend & en;
                run(2'h1, 1'h1, vec(pm));
                pend = pend & ~(pm & (~pm + 14'h0001));
            end
            run(2'h1, 1'h0, 16'h0000);
            rq(pend);
            wr(ad(IDX_REQ1), 8'h00);
            wr(ad(IDX_REQ2), 8'h00);
        end
        break_instruction <= 1'h1;
        run(2'h0, 1'h1, VEC_BRK_HI);
        rd(ad(IDX_ISTAT), 8'h03, 8'hFF);
        wr(ad(IDX_IMASK), 8'h02);
        repeat (2) @(posedge i_clock);
        chk(16'(o_irq), 16'h0001);
        wr(ad(IDX_ISTAT), 8'h02);
        repeat (2) @(posedge i_clock);
        chk(16'(o_irq), 16'h0000);
        rd(ad(IDX_ISTAT), 8'h01, 8'hFF);
        results();
    end
endmodule
`default_nettype wire
